//--- hdl/crcbe_map.svh
// Register offsets, reset values and polynomial constants of the CRC byte engine
`ifndef CRCBE_MAP_SVH
`define CRCBE_MAP_SVH
`define CRCBE_OFF_HIGH     4'h0
`define CRCBE_OFF_LOW      4'h4
`define CRCBE_OFF_STOP     4'h8
`define CRCBE_STOP_LIGHT   0
`define CRCBE_STOP_DEEP    1
`define CRCBE_POLY         16'h1021
`define CRCBE_CRC_RESET    16'h0000
`define CRCBE_READ_UNMAPPED 32'h0000_0000
`endif

//--- hdl/crcbe_pkg.sv
// Types of the CRC byte engine
package crcbe_pkg;
	typedef logic [15:0] crcbe_crc_t;
	typedef logic [7:0]  crcbe_byte_t;
	typedef enum logic [1:0] {CRCBE_IDLE, CRCBE_ARMED} crcbe_seed_e;
endpackage

//--- hdl/crcbe_top.sv
// CRC16-CCITT byte engine with Avalon-MM slave
// Functional notes
// - High write loads byte into CRC bits 15:8 and arms seed sequence.
// - Armed low write loads CRC bits 7:0, disarms, no shifting.
// - Unarmed low write is message data clocked through 16-bit generator.
// - Message bits enter MSB first, LSB last.
// - All 8 bits done; result readable next bus cycle.
// - High read returns current CRC bits 15:8.
// - Low read returns current CRC bits 7:0.
// - Polynomial x^16+x^12+x^5+1, 0x1021.
// - Direct circuit, programmable seed, no augmentation, result never complemented.
// - New CRC value presented after every 8 bits shifted.
// - Later high write starts a fresh independent calculation.
// - "123456789" gives 0x31c3 with seed 0, 0x29b1 with seed 0xffff.
// - Seed 0x1d0f matches zero-augmented variant with seed 0xffff.
// - Recovery from deep stop returns all CRC state to reset.
// - Light stop freezes calculation; resumes unchanged on return.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "crcbe_map.svh"
module crcbe_top
	import crcbe_pkg::*;
(
	input  wire logic        clk,           // 40 MHz bus clock
	input  wire logic        reset_n,       // Async reset, active low
	input  wire logic [3:0]  address,       // Byte address
	input  wire logic        read,          // Read request
	input  wire logic        write,         // Write request
	input  wire logic [31:0] writedata,     // Write data
	input  wire logic [3:0]  byteenable,    // Byte lanes
	output logic      [31:0] readdata,      // Read data
	output logic             waitrequest,   // Stall
	output crcbe_pkg::crcbe_crc_t crc_value // Current CRC
);
	import crcbe_pkg::*;

	crcbe_crc_t  crc;
	crcbe_seed_e seed_state;
	logic [1:0]  stop_ctl;
	logic        light_stop;
	logic        deep_stop;
	logic        deep_exit;
	logic        rd_ready;
	logic        stall;
	logic        wr_high;
	logic        wr_low;
	logic        wr_stop;
	crcbe_crc_t  next_crc;

	// Light stop stalls the bus so a write, except to stop control, waits until run mode
	assign light_stop  = stop_ctl[`CRCBE_STOP_LIGHT];
	assign deep_stop   = stop_ctl[`CRCBE_STOP_DEEP];
	assign stall       = light_stop & ~(write & (address == `CRCBE_OFF_STOP));
	// Writes take no wait state outside light stop; reads wait one cycle for registered data
	assign waitrequest = (write & stall) | (read & (stall | ~rd_ready));
	assign wr_high = write & ~waitrequest & (address == `CRCBE_OFF_HIGH) & byteenable[0];
	assign wr_low  = write & ~waitrequest & (address == `CRCBE_OFF_LOW) & byteenable[0];
	assign wr_stop = write & ~waitrequest & (address == `CRCBE_OFF_STOP) & byteenable[0];
	// Deep stop exit resets state at the edge taking the clearing write
	assign deep_exit = wr_stop & deep_stop & ~writedata[`CRCBE_STOP_DEEP];
	assign crc_value = crc;

	// Whole byte through the generator in one cycle, MSB first
	always_comb
	begin
		next_crc = crc;
		for (int i = 7; i >= 0; i--)
		begin
			if (next_crc[15] ^ writedata[i])
				next_crc = {next_crc[14:0], 1'b0} ^ `CRCBE_POLY;
			else
				next_crc = {next_crc[14:0], 1'b0};
		end
	end

	// Read data captured; the read is answered in the next cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rd_ready <= 1'b0;
		else
			rd_ready <= read & ~stall & ~rd_ready;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			stop_ctl <= 2'h0;
		else if (wr_stop)
			stop_ctl <= writedata[1:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			seed_state <= CRCBE_IDLE;
		else if (deep_exit)
			seed_state <= CRCBE_IDLE;
		else if (wr_high)
			seed_state <= CRCBE_ARMED;
		else if (wr_low)
			seed_state <= CRCBE_IDLE;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			crc <= `CRCBE_CRC_RESET;
		else if (deep_exit)
			crc <= `CRCBE_CRC_RESET;
		else if (wr_high)
			crc[15:8] <= writedata[7:0];
		else if (wr_low)
		begin
			case (seed_state)
				CRCBE_ARMED: crc[7:0] <= writedata[7:0];
				CRCBE_IDLE:  crc <= next_crc;
				default:     crc <= crc;
			endcase
		end
	end

	// Registered read data, from the live shift register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			readdata <= 32'h0000_0000;
		else if (read & ~stall & ~rd_ready)
		begin
			case (address)
				`CRCBE_OFF_HIGH: readdata <= {24'h00_0000, crc[15:8]};
				`CRCBE_OFF_LOW:  readdata <= {24'h00_0000, crc[7:0]};
				`CRCBE_OFF_STOP: readdata <= {24'h00_0000, 6'h00, stop_ctl};
				default:         readdata <= `CRCBE_READ_UNMAPPED;
			endcase
		end
	end

	// Reference step of the generator for checking
	function automatic crcbe_crc_t ref_step(input crcbe_crc_t c, input crcbe_byte_t d);
		crcbe_crc_t r;
		r = c ^ {d, 8'h00};
		for (int k = 0; k < 8; k++)
			r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
		return r;
	endfunction

	property p_seed_high;
		@(posedge clk) disable iff (!reset_n)
		wr_high & ~deep_exit |=> (crc[15:8] == $past(writedata[7:0])) && (seed_state == CRCBE_ARMED);
	endproperty
	a_seed_high: assert property (p_seed_high) else $error("High write did not seed");

	property p_seed_low;
		@(posedge clk) disable iff (!reset_n)
		wr_low & ~deep_exit & (seed_state == CRCBE_ARMED) |=>
			(crc == {$past(crc[15:8]), $past(writedata[7:0])}) && (seed_state == CRCBE_IDLE);
	endproperty
	a_seed_low: assert property (p_seed_low) else $error("Low seed write wrong");

	property p_data_byte;
		@(posedge clk) disable iff (!reset_n)
		wr_low & ~deep_exit & (seed_state == CRCBE_IDLE) |=>
			crc == ref_step($past(crc), $past(writedata[7:0]));
	endproperty
	a_data_byte: assert property (p_data_byte) else $error("Data byte CRC wrong");

	property p_hold;
		@(posedge clk) disable iff (!reset_n)
		~wr_low & ~wr_high & ~deep_exit |=> $stable(crc);
	endproperty
	a_hold: assert property (p_hold) else $error("CRC changed without write");

	property p_read_high;
		@(posedge clk) disable iff (!reset_n)
		read & ~waitrequest & (address == `CRCBE_OFF_HIGH) |-> readdata == {24'h00_0000, crc[15:8]};
	endproperty
	a_read_high: assert property (p_read_high) else $error("High read wrong");

	property p_read_low;
		@(posedge clk) disable iff (!reset_n)
		read & ~waitrequest & (address == `CRCBE_OFF_LOW) |-> readdata == {24'h00_0000, crc[7:0]};
	endproperty
	a_read_low: assert property (p_read_low) else $error("Low read wrong");

	property p_deep_reset;
		@(posedge clk) disable iff (!reset_n)
		deep_exit |=> (crc == 16'h0000) && (seed_state == CRCBE_IDLE);
	endproperty
	a_deep_reset: assert property (p_deep_reset) else $error("Deep stop exit not reset");

	property p_light_stall;
		@(posedge clk) disable iff (!reset_n)
		light_stop & write & (address == `CRCBE_OFF_LOW) |-> waitrequest;
	endproperty
	a_light_stall: assert property (p_light_stall) else $error("Light stop did not stall");

	property p_reset_idle;
		@(posedge clk)
		$rose(reset_n) |-> seed_state == CRCBE_IDLE;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("Armed after reset");

	// Bus timing and register checks
	property p_wr_no_wait;
		@(posedge clk) disable iff (!reset_n)
		write & ~light_stop |-> ~waitrequest;
	endproperty
	a_wr_no_wait: assert property (p_wr_no_wait) else $error("Write stalled outside light stop");

	property p_rd_one_wait;
		@(posedge clk) disable iff (!reset_n)
		read & ~rd_ready |-> waitrequest;
	endproperty
	a_rd_one_wait: assert property (p_rd_one_wait) else $error("Read answered before data ready");

	property p_rd_ready_pulse;
		@(posedge clk) disable iff (!reset_n)
		rd_ready |=> ~rd_ready;
	endproperty
	a_rd_ready_pulse: assert property (p_rd_ready_pulse) else $error("Read ready held too long");

	property p_stop_exempt;
		@(posedge clk) disable iff (!reset_n)
		write & (address == `CRCBE_OFF_STOP) |-> ~waitrequest;
	endproperty
	a_stop_exempt: assert property (p_stop_exempt) else $error("Stop control write stalled");

	property p_stall_read;
		@(posedge clk) disable iff (!reset_n)
		light_stop & read |-> waitrequest;
	endproperty
	a_stall_read: assert property (p_stall_read) else $error("Read not stalled in light stop");

	property p_be_ignored;
		@(posedge clk) disable iff (!reset_n)
		write & ~byteenable[0] |=> $stable(crc) && $stable(stop_ctl) && $stable(seed_state);
	endproperty
	a_be_ignored: assert property (p_be_ignored) else $error("Masked write took effect");

	property p_unmapped_read;
		@(posedge clk) disable iff (!reset_n)
		read & ~waitrequest & (address != `CRCBE_OFF_HIGH) & (address != `CRCBE_OFF_LOW)
			& (address != `CRCBE_OFF_STOP) |-> readdata == 32'h0000_0000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

	property p_read_stop;
		@(posedge clk) disable iff (!reset_n)
		read & ~waitrequest & (address == `CRCBE_OFF_STOP) |-> readdata == {24'h00_0000, 6'h00, stop_ctl};
	endproperty
	a_read_stop: assert property (p_read_stop) else $error("Stop control read wrong");

	property p_stop_write;
		@(posedge clk) disable iff (!reset_n)
		wr_stop |=> stop_ctl == $past(writedata[1:0]);
	endproperty
	a_stop_write: assert property (p_stop_write) else $error("Stop control write lost");

	property p_readdata_hold;
		@(posedge clk) disable iff (!reset_n)
		~(read & ~light_stop & ~rd_ready) |=> $stable(readdata);
	endproperty
	a_readdata_hold: assert property (p_readdata_hold) else $error("Read data moved without read");

	property p_high_keeps_low;
		@(posedge clk) disable iff (!reset_n)
		wr_high & ~deep_exit |=> crc[7:0] == $past(crc[7:0]);
	endproperty
	a_high_keeps_low: assert property (p_high_keeps_low) else $error("High write touched low byte");

	property p_light_freeze;
		@(posedge clk) disable iff (!reset_n)
		light_stop & ~deep_exit |=> $stable(crc) && $stable(seed_state);
	endproperty
	a_light_freeze: assert property (p_light_freeze) else $error("State moved in light stop");

	property p_data_stays_idle;
		@(posedge clk) disable iff (!reset_n)
		wr_low & (seed_state == CRCBE_IDLE) |=> seed_state == CRCBE_IDLE;
	endproperty
	a_data_stays_idle: assert property (p_data_stays_idle) else $error("Data byte armed seed");

	property p_read_no_effect;
		@(posedge clk) disable iff (!reset_n)
		read & ~write |=> $stable(crc) && $stable(seed_state);
	endproperty
	a_read_no_effect: assert property (p_read_no_effect) else $error("Read altered CRC state");

	property p_idle_stays;
		@(posedge clk) disable iff (!reset_n)
		(seed_state == CRCBE_IDLE) & ~wr_high |=> seed_state == CRCBE_IDLE;
	endproperty
	a_idle_stays: assert property (p_idle_stays) else $error("Seed armed without high write");

	property p_msb_first;
		@(posedge clk) disable iff (!reset_n)
		wr_low & (seed_state == CRCBE_IDLE) & (crc == 16'h0000) & (writedata[7:0] == 8'h01) |=> crc == `CRCBE_POLY;
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("Bit order or polynomial wrong");

	property p_waitreq_idle;
		@(posedge clk) disable iff (!reset_n)
		~read & ~write |-> ~waitrequest;
	endproperty
	a_waitreq_idle: assert property (p_waitreq_idle) else $error("Stall without request");

	property p_rd_ready_cause;
		@(posedge clk) disable iff (!reset_n)
		rd_ready |-> $past(read) && !$past(light_stop);
	endproperty
	a_rd_ready_cause: assert property (p_rd_ready_cause) else $error("Read ready without read");

	property p_light_stall_high;
		@(posedge clk) disable iff (!reset_n)
		light_stop & write & (address == `CRCBE_OFF_HIGH) |-> waitrequest;
	endproperty
	a_light_stall_high: assert property (p_light_stall_high) else $error("High write not stalled");

	property p_write_no_readdata;
		@(posedge clk) disable iff (!reset_n)
		write |=> $stable(readdata);
	endproperty
	a_write_no_readdata: assert property (p_write_no_readdata) else $error("Write moved read data");

	property p_readdata_upper;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |-> readdata[31:8] == 24'h00_0000;
	endproperty
	a_readdata_upper: assert property (p_readdata_upper) else $error("Upper read data not zero");

	property p_no_stop_change;
		@(posedge clk) disable iff (!reset_n)
		~wr_stop |=> $stable(stop_ctl);
	endproperty
	a_no_stop_change: assert property (p_no_stop_change) else $error("Stop control moved alone");

	property p_armed_hold;
		@(posedge clk) disable iff (!reset_n)
		(seed_state == CRCBE_ARMED) & ~wr_low & ~deep_exit |=> seed_state == CRCBE_ARMED;
	endproperty
	a_armed_hold: assert property (p_armed_hold) else $error("Seed sequence dropped");

	c_seed: cover property (@(posedge clk) disable iff (!reset_n) wr_high ##[1:4] wr_low ##[1:4] wr_low);
	c_data2: cover property (@(posedge clk) disable iff (!reset_n) wr_low ##1 wr_low);
	c_light: cover property (@(posedge clk) disable iff (!reset_n) light_stop & write ##1 waitrequest);
	c_deep: cover property (@(posedge clk) disable iff (!reset_n) deep_exit);
endmodule // crcbe_top

//--- dv/testbench.sv
// Self-checking bench for the CRC byte engine
`timescale 1ns/1ps
module testbench;
	import crcbe_pkg::*;
	typedef struct {crcbe_crc_t seed; crcbe_byte_t first; int step; int len; crcbe_crc_t exp;} crcbe_row_s;
	logic        clk, reset_n, read, write, waitrequest;
	logic [3:0]  address, byteenable;
	logic [31:0] writedata, readdata, got;
	crcbe_crc_t  crc_value;
	int          miscompares = 0, compares = 0, cycles = 0;
	crcbe_row_s  rows [9] = '{
		'{16'h0000, 8'h41, 0, 1, 16'h58e5}, '{16'hffff, 8'h41, 0, 1, 16'hb915}, '{16'h1d0f, 8'h41, 0, 1, 16'h9479},
		'{16'h0000, 8'h31, 1, 9, 16'h31c3}, '{16'hffff, 8'h31, 1, 9, 16'h29b1}, '{16'h1d0f, 8'h31, 1, 9, 16'he5cc},
		'{16'h0000, 8'h41, 0, 256, 16'habe3}, '{16'hffff, 8'h41, 0, 256, 16'hea0b}, '{16'h1d0f, 8'h41, 0, 256, 16'he938}};
	crcbe_top i_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.crc_value(crc_value));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Called just after a rising edge; returns just after the accepting edge
	task automatic bus(input logic wr, input logic [3:0] adr, input crcbe_byte_t dat, input logic [3:0] be);
		logic w;
		address <= adr;
		writedata <= {24'h00_0000, dat};
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		do
		begin
			@(negedge clk) w = waitrequest;
			@(posedge clk);
		end while (w !== 1'b0);
	endtask
	task automatic wr(input logic [3:0] adr, input crcbe_byte_t dat);
		bus(1'b1, adr, dat, 4'h1);
	endtask
	// Read data taken at the accepting edge
	task automatic rd(input logic [3:0] adr);
		bus(1'b0, adr, 8'h00, 4'h1);
		got = readdata;
	endtask
	task automatic rd_crc(input crcbe_crc_t e);
		logic [7:0] h;
		rd(4'h0);
		h = got[7:0];
		rd(4'h4);
		chk({16'h0000, h, got[7:0]}, {16'h0000, e});
	endtask
	initial
	begin
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 4'h0;
		writedata = 32'h0000_0000;
		byteenable = 4'h1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk) chk({16'h0000, crc_value}, 32'h0000_0000);
		@(posedge clk);
		foreach (rows[r])
		begin
			wr(4'h0, rows[r].seed[15:8]);
			wr(4'h4, rows[r].seed[7:0]);
			for (int i = 0; i < rows[r].len; i++)
				wr(4'h4, crcbe_byte_t'(rows[r].first + rows[r].step * i));
			rd_crc(rows[r].exp);
		end
		wr(4'h0, 8'hab);
		rd(4'h0);
		chk(got, 32'h0000_00ab);
		wr(4'h4, 8'hcd);
		bus(1'b1, 4'h4, 8'h55, 4'h0);
		rd_crc(16'habcd);
		wr(4'h4, 8'h31);
		wr(4'h0, 8'h00);
		wr(4'h4, 8'h00);
		wr(4'h4, 8'h41);
		rd_crc(16'h58e5);
		rd(4'hc);
		chk(got, 32'h0000_0000);
		wr(4'h8, 8'h01);
		address <= 4'h4;
		writedata <= 32'h0000_0041;
		repeat (3) @(negedge clk) chk({31'h0, waitrequest}, 32'h0000_0001);
		@(posedge clk);
		write <= 1'b0;
		@(posedge clk);
		wr(4'h8, 8'h00);
		rd_crc(16'h58e5);
		wr(4'h0, 8'h12);
		wr(4'h8, 8'h02);
		rd(4'h8);
		chk(got, 32'h0000_0002);
		wr(4'h8, 8'h00);
		wr(4'h4, 8'h41);
		rd_crc(16'h58e5);
		wr(4'h0, 8'h00);
		wr(4'h4, 8'h00);
		wr(4'h4, 8'h01);
		rd_crc(16'h1021);
		wr(4'h0, 8'h12);
		write <= 1'b0;
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		wr(4'h4, 8'h41);
		rd_crc(16'h58e5);
		close_out();
	end
endmodule // testbench
